// ==== rtl/cmr_defines.svh ====
`ifndef CMR_DEFINES_SVH
`define CMR_DEFINES_SVH
`define CMR_ADDR 6'h05
`define CMR_RESET 24'he00000
`define CMR_WMASK 24'he073ff
`define CMR_CM_HI 23
`define CMR_CM_LO 21
`define CMR_DS_HI 14
`define CMR_DS_LO 12
`define CMR_CE_DS 9
`define CMR_CE_REF 8
`define CMR_SEL_HI 7
`define CMR_SEL_LO 4
`define CMR_DRV 3
`define CMR_EXT 2
`define CMR_RLDREF 1
`define CMR_SHLD 0
`endif

// ==== rtl/cmr_pkg.sv ====
package cmr_pkg;
   typedef enum logic [1:0] {
      cmr_src_avg_type = 2'b00,
      cmr_src_ref_type = 2'b01,
      cmr_src_ext_type = 2'b10
   } cmr_src_type;
   typedef enum logic [3:0] {
      cmr_drv_pin = 4'h0,
      cmr_drv_left_arm = 4'h1,
      cmr_drv_left_leg = 4'h2,
      cmr_drv_right_arm = 4'h3
   } cmr_drive_sel_type;
endpackage

// ==== rtl/cmr_wr_if.sv ====
`timescale 1ns/10ps
interface cmr_wr_if;
   logic wr_en;
   logic [23:0] wr_data;
   logic [23:0] value;
   modport bank(input wr_en, input wr_data, output value);
   modport user(output wr_en, output wr_data, input value);
endinterface

// ==== rtl/cmr_bank.sv ====
`timescale 1ns/10ps
`include "cmr_defines.svh"
module cmr_bank (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // write port
   cmr_wr_if.bank wr
);
   logic [23:0] value_reg;
   logic [23:0] value_next;
   // reserved bits are held at zero even if software slips
   assign value_next = wr.wr_en ? (wr.wr_data & `CMR_WMASK) : value_reg;
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         value_reg <= `CMR_RESET;
      end else begin
         value_reg <= value_next;
      end
   end
   assign wr.value = value_reg;
   a_reset_value: assert property (@(posedge ref_clk_i)
      !resetn_i |=> value_reg == `CMR_RESET) else $error("bad reset value");
   a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (value_reg & ~`CMR_WMASK) == 24'h000000) else $error("reserved bit set");
endmodule

// ==== rtl/cmr_ctrl.sv ====
`timescale 1ns/10ps
`include "cmr_defines.svh"
module cmr_ctrl (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // register port from the serial host port
   input wire logic reg_wr_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic [23:0] reg_wdata_i,
   output logic [23:0] reg_rdata_o,
   // analog switch controls
   output logic [2:0] cm_switch_o,
   output cmr_pkg::cmr_src_type cm_source_o,
   output logic [1:0] cm_count_o,
   output logic cm_pin_drive_o,
   output logic [2:0] drive_sum_select_o,
   output logic common_electrode_drive_sum_select_o,
   output logic common_electrode_reference_enable_o,
   output logic [3:0] drive_electrode_onehot_o,
   output logic reference_drive_reserved_o,
   output logic right_leg_reference_enable_o,
   output logic shield_driver_enable_o
);
   import cmr_pkg::*;

   // ==========================================
   // register
   cmr_wr_if wr();
   logic hit;
   assign hit = reg_wr_i && (reg_addr_i == `CMR_ADDR);
   assign wr.wr_en = hit;
   assign wr.wr_data = reg_wdata_i;
   cmr_bank u_bank (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .wr(wr)
   );
   logic [23:0] r;
   assign r = wr.value;

   // ==========================================
   // decode
   // the count feeds the averaging divider, so one electrode divides by one
   function automatic logic [1:0] ones3(input logic [2:0] v);
      ones3 = {1'h0, v[0]} + {1'h0, v[1]} + {1'h0, v[2]};
   endfunction
   logic ext;
   logic [2:0] cm_sel;
   logic [2:0] sw_next;
   logic [1:0] count_next;
   cmr_src_type src_next;
   logic [3:0] sel;
   logic sel_reserved;
   logic [3:0] onehot_next;
   logic pin_next;
   assign ext = r[`CMR_EXT];
   assign cm_sel = r[`CMR_CM_HI:`CMR_CM_LO];
   // external source opens every internal switch whatever the select bits say
   for (genvar i = 0; i < 3; i++) begin : g_switch
      assign sw_next[i] = cm_sel[i] && !ext;
   end
   assign count_next = ones3(sw_next);
   assign src_next = ext ? cmr_src_ext_type :
      (cm_sel == 3'h0) ? cmr_src_ref_type : cmr_src_avg_type;
   assign sel = r[`CMR_SEL_HI:`CMR_SEL_LO];
   assign sel_reserved = (sel > 4'h3);
   // reserved codes select nothing rather than a random electrode
   assign onehot_next = sel_reserved ? 4'h0 : (4'h1 << sel[1:0]);
   // drive bit is dead while an external source is in use
   assign pin_next = r[`CMR_DRV] && !ext;

   // ==========================================
   // outputs
   // reset values equal the decode of the register reset word, so no glitch at release
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= `CMR_RESET;
      end else begin
         reg_rdata_o <= r;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cm_switch_o <= 3'h7;
      end else begin
         cm_switch_o <= sw_next;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cm_source_o <= cmr_src_avg_type;
      end else begin
         cm_source_o <= src_next;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cm_count_o <= 2'h3;
      end else begin
         cm_count_o <= count_next;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cm_pin_drive_o <= 1'h0;
      end else begin
         cm_pin_drive_o <= pin_next;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         drive_sum_select_o <= 3'h0;
      end else begin
         drive_sum_select_o <= r[`CMR_DS_HI:`CMR_DS_LO];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         common_electrode_drive_sum_select_o <= 1'h0;
      end else begin
         common_electrode_drive_sum_select_o <= r[`CMR_CE_DS];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         common_electrode_reference_enable_o <= 1'h0;
      end else begin
         common_electrode_reference_enable_o <= r[`CMR_CE_REF];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         drive_electrode_onehot_o <= 4'h1;
      end else begin
         drive_electrode_onehot_o <= onehot_next;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         reference_drive_reserved_o <= 1'h0;
      end else begin
         reference_drive_reserved_o <= sel_reserved;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         right_leg_reference_enable_o <= 1'h0;
      end else begin
         right_leg_reference_enable_o <= r[`CMR_RLDREF];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         shield_driver_enable_o <= 1'h0;
      end else begin
         shield_driver_enable_o <= r[`CMR_SHLD];
      end
   end

   // ==========================================
   // checks
   // a write lands at its edge and shows on the outputs one edge later
   sequence s_ext_write;
      hit && reg_wdata_i[`CMR_EXT];
   endsequence
   sequence s_int_write;
      hit && !reg_wdata_i[`CMR_EXT];
   endsequence
   sequence s_quiet;
      !hit;
   endsequence

   a_ext_opens: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      s_ext_write |-> ##2 cm_switch_o == 3'h0 && !cm_pin_drive_o)
      else $error("switches closed under external source");
   a_cm_follow: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      s_int_write |-> ##2 cm_switch_o == $past(reg_wdata_i[`CMR_CM_HI:`CMR_CM_LO], 2))
      else $error("electrode select not applied");
   a_ref_fallback: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      cm_source_o == cmr_src_ref_type |-> cm_switch_o == 3'h0 && cm_count_o == 2'h0)
      else $error("fixed reference with electrodes selected");
   a_ref_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      s_int_write ##0 reg_wdata_i[`CMR_CM_HI:`CMR_CM_LO] == 3'h0 |-> ##2
      cm_source_o == cmr_src_ref_type)
      else $error("fixed reference not chosen");
   a_avg_count: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      cm_source_o == cmr_src_avg_type |-> cm_count_o != 2'h0)
      else $error("average with no electrodes");
   a_drive_gated: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      cm_pin_drive_o |-> cm_source_o != cmr_src_ext_type)
      else $error("pin driven under external source");
   a_pin_follow: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      s_int_write |-> ##2 cm_pin_drive_o == $past(reg_wdata_i[`CMR_DRV], 2))
      else $error("pin drive not applied");
   a_sel_decode: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      reference_drive_reserved_o |-> drive_electrode_onehot_o == 4'h0)
      else $error("reserved code selects electrode");
   a_sel_follow: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      hit && reg_wdata_i[`CMR_SEL_HI:`CMR_SEL_LO] < 4'h4 |-> ##2
      drive_electrode_onehot_o == 4'h1 << $past(reg_wdata_i[`CMR_SEL_HI:`CMR_SEL_LO], 2))
      else $error("electrode code not decoded");
   a_sum_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      hit |-> ##2 drive_sum_select_o == $past(reg_wdata_i[`CMR_DS_HI:`CMR_DS_LO], 2))
      else $error("drive sum select not applied");
   a_enable_bits: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      hit |-> ##2 shield_driver_enable_o == $past(reg_wdata_i[`CMR_SHLD], 2) &&
      right_leg_reference_enable_o == $past(reg_wdata_i[`CMR_RLDREF], 2))
      else $error("enable bit not applied");
   a_common_bits: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      hit |-> ##2 common_electrode_reference_enable_o == $past(reg_wdata_i[`CMR_CE_REF], 2) &&
      common_electrode_drive_sum_select_o == $past(reg_wdata_i[`CMR_CE_DS], 2))
      else $error("common electrode bit not applied");
   a_rdata_follow: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      hit |-> ##2 reg_rdata_o == $past(reg_wdata_i & `CMR_WMASK, 2))
      else $error("read back differs from write");
   a_quiet_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      s_quiet |-> ##2 $stable(reg_rdata_o) && $stable(cm_switch_o) &&
      $stable(drive_electrode_onehot_o) && $stable(cm_source_o))
      else $error("output moved without a write");
endmodule

// ==== tb/cmr_ctrl_tb.sv ====
`timescale 1ns/10ps
module cmr_ctrl_tb;
   import cmr_pkg::*;
   // ==========
   // stimulus and observed ports
   logic ref_clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0;
   logic [5:0] reg_addr_i = 6'h00;
   logic [23:0] reg_wdata_i = 24'h000000, reg_rdata_o;
   logic [2:0] cm_switch_o, drive_sum_select_o;
   cmr_src_type cm_source_o;
   logic [1:0] cm_count_o;
   logic [3:0] drive_electrode_onehot_o;
   logic cm_pin_drive_o, ce_sum, ce_ref, rsv, rld_ref, shield;
   int n_errors = 0, n_checks = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   cmr_ctrl DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .cm_switch_o(cm_switch_o), .cm_source_o(cm_source_o), .cm_count_o(cm_count_o),
      .cm_pin_drive_o(cm_pin_drive_o), .drive_sum_select_o(drive_sum_select_o),
      .common_electrode_drive_sum_select_o(ce_sum),
      .common_electrode_reference_enable_o(ce_ref),
      .drive_electrode_onehot_o(drive_electrode_onehot_o),
      .reference_drive_reserved_o(rsv), .right_leg_reference_enable_o(rld_ref),
      .shield_driver_enable_o(shield));
   // ==========
   // shared tasks
   task stop_test;
      if (n_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task cmp(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // strobe is one cycle; outputs settle two edges after the write
   task wr(input logic [5:0] a, input logic [23:0] d);
      @(negedge ref_clk_i) reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge ref_clk_i) reg_wr_i = 1'b0;
      @(negedge ref_clk_i);
   endtask
   task check(input logic [23:0] r);
      logic [2:0] sw;
      logic [3:0] c;
      sw = r[2] ? 3'h0 : r[23:21];
      c = r[7:4];
      cmp(reg_rdata_o, r);
      cmp(24'(cm_switch_o), 24'(sw));
      cmp(24'(cm_source_o), r[2] ? 24'h2 : (sw == 3'h0 ? 24'h1 : 24'h0));
      cmp(24'(cm_count_o), 24'($countones(sw)));
      cmp(24'(cm_pin_drive_o), 24'(r[3] & ~r[2]));
      cmp(24'(drive_sum_select_o), 24'(r[14:12]));
      cmp(24'(ce_sum), 24'(r[9]));
      cmp(24'(ce_ref), 24'(r[8]));
      cmp(24'(drive_electrode_onehot_o), c < 4'h4 ? 24'h1 << c : 24'h0);
      cmp(24'(rsv), 24'(c > 4'h3));
      cmp(24'(rld_ref), 24'(r[1]));
      cmp(24'(shield), 24'(r[0]));
   endtask
   // ==========
   // scenarios
   task t_bad_addr;
      wr(6'h06, 24'h00ffff);
      wr(6'h25, 24'h1fffff);
      check(24'he00000);
   endtask
   // every writable bit set; reserved ranges stay zero as software must keep them
   task t_all_ones;
      wr(6'h05, 24'he073ff);
      check(24'he073ff);
   endtask
   task t_cm_sel;
      for (int v = 0; v < 8; v++) begin
         wr(6'h05, {3'(v), 21'h000008});
         check({3'(v), 21'h000008});
      end
   endtask
   task t_field;
      for (int c = 0; c < 16; c++) begin
         wr(6'h05, {16'h6000, 4'(c), 4'(c)});
         check({16'h6000, 4'(c), 4'(c)});
      end
   endtask
   // back to back: the first value shows on the outputs at the same edge the second lands
   task t_back;
      @(negedge ref_clk_i) reg_wr_i = 1'b1;
      reg_addr_i = 6'h05;
      reg_wdata_i = 24'h205318;
      @(negedge ref_clk_i) reg_wdata_i = 24'h4022a5;
      @(negedge ref_clk_i) reg_wr_i = 1'b0;
      check(24'h205318);
      @(negedge ref_clk_i);
      check(24'h4022a5);
   endtask
   task t_reset_mid;
      wr(6'h05, 24'h0073ff);
      @(negedge ref_clk_i) resetn_i = 1'b0;
      @(negedge ref_clk_i) resetn_i = 1'b1;
      check(24'he00000);
   endtask
   // ==========
   // main sequence and watchdog
   initial begin
      repeat (8) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      check(24'he00000);
      t_bad_addr();
      t_all_ones();
      t_cm_sel();
      t_field();
      t_back();
      t_reset_mid();
      stop_test();
   end
   initial begin
      #100000;
      n_errors++;
      stop_test();
   end
endmodule
